// ===== rtl/sas_top.sv
// Contract
// - Codes 0 to 10 route analog inputs 0 to 10; others prohibited
// - Code 1101 selects the internal reference as conversion target
// - Discharge bit 1 converts ground; 0 converts the coded target
// - Reset clears channel select and test select
// - Conversion samples first, then holds until conversion ends
// - After hold, bit 9 is set and tap goes to half supply
// - Comparator high keeps tested bit, low clears it
// - Next lower bit set tentatively; tap follows decided bits
// - Input at or above tap keeps trial bit, below clears it
// - Trials run down to bit 0, ten comparisons per conversion
// - Last comparison copies result and raises done interrupt together
// - Run bit self-clears on completion; block returns to standby
// - Each write of one to the run bit with the converter enabled starts one conversion; here enable must be set before and in that same write
// - Reset clears result word and high byte view
// - Result word holds the ten-bit code times 64
// - Result word low six bits zero; high byte shows bits 9 to 2
// - Clearing run bit mid conversion abandons it to standby
// - Run set while converter disabled is ignored
// - Mode write colliding with result store wins: no store, no irq
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "sas_consts.svh"
module sas_top
   import sas_pkg::*;
#(
   parameter int SAMPLE_CYC = `SAS_SAMPLE_CYC,
   parameter int STEP_CYC = `SAS_STEP_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SAS_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp_above,
   output sas_analog_s analog,
   output logic conv_done_irq,
   output logic conversion_run_bit
);
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] chan_q;
   logic dis_q;
   logic en_q;
   logic [9:0] res_q;
   sas_state_e st_q;
   logic [7:0] cnt_q;
   logic [3:0] idx_q;
   logic cmp_s;
   logic [9:0] sar_q;
   logic [9:0] sar_d;
   logic [19:0] widx;
   logic setup;
   logic access;
   logic hit_test;
   logic hit_chan;
   logic hit_mode;
   logic hit_res;
   logic hit_resh;
   logic wr_ok;
   logic wr_mode;
   logic start;
   logic samp_end;
   logic step_end;
   logic decide;
   logic finish;

   // All checks below run on pclk and are off while in reset
   default clocking ck @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   assign widx = paddr[`SAS_AW-1:2];
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign hit_test = (widx == `SAS_IDX_TEST);
   assign hit_chan = (widx == `SAS_IDX_CHAN);
   assign hit_mode = (widx == `SAS_IDX_MODE0);
   assign hit_res = (widx == `SAS_IDX_RES);
   assign hit_resh = (widx == `SAS_IDX_RESH);
   assign wr_ok = access & pwrite & pstrb[0];
   assign wr_mode = wr_ok & hit_mode;
   // A start needs the converter already enabled and kept enabled
   assign start = wr_mode & pwdata[`SAS_RUN_BIT] & pwdata[`SAS_EN_BIT]
                  & en_q;
   assign samp_end = (st_q == SAS_SAMPLE) && (cnt_q == 8'(SAMPLE_CYC - 1));
   assign step_end = (st_q == SAS_TRIAL) && (cnt_q == 8'(STEP_CYC - 1));
   assign decide = step_end & ~wr_mode;
   assign finish = step_end && (idx_q == 4'h0);

   ////////////////////////////////////////////////////////////////////////
   // APB slave with no wait state; read data is registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~(hit_test | hit_chan | hit_mode | hit_res
                              | hit_resh);
         prdata <= 32'h0000_0000;
         if (setup && !pwrite)
         begin
            if (hit_test)
               prdata <= {30'h0, dis_q, 1'b0};
            else if (hit_chan)
               prdata <= {28'h0, chan_q};
            else if (hit_mode)
               prdata <= {24'h0, conversion_run_bit, 6'h00, en_q};
            else if (hit_res)
               prdata <= {16'h0, res_q, 6'h00};
            else if (hit_resh)
               prdata <= {24'h0, res_q[9:2]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration; reserved bits are not stored and read as zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chan_q <= `SAS_CHAN_RST;
         dis_q <= `SAS_TEST_RST;
      end
      else
      begin
         if (wr_ok && hit_chan)
            chan_q <= pwdata[3:0];
         if (wr_ok && hit_test)
            dis_q <= pwdata[`SAS_DIS_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_q <= 1'b0;
         conversion_run_bit <= 1'b0;
      end
      else if (wr_mode)
      begin
         en_q <= pwdata[`SAS_EN_BIT];
         conversion_run_bit <= start;
      end
      else if (finish)
         conversion_run_bit <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer; a mode write always restarts or aborts the conversion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= SAS_IDLE;
         cnt_q <= 8'h00;
         idx_q <= 4'h0;
      end
      else if (wr_mode)
      begin
         st_q <= start ? SAS_SAMPLE : SAS_IDLE;
         cnt_q <= 8'h00;
      end
      else
      begin
         case (st_q)
            SAS_IDLE:
            begin
               cnt_q <= 8'h00;
            end
            SAS_SAMPLE:
            begin
               cnt_q <= cnt_q + 8'h01;
               if (samp_end)
               begin
                  st_q <= SAS_TRIAL;
                  cnt_q <= 8'h00;
                  idx_q <= 4'(`SAS_NBITS - 1);
               end
            end
            SAS_TRIAL:
            begin
               cnt_q <= cnt_q + 8'h01;
               if (step_end)
               begin
                  cnt_q <= 8'h00;
                  if (idx_q == 4'h0)
                     st_q <= SAS_IDLE;
                  else
                     idx_q <= idx_q - 4'h1;
               end
            end
            default:
            begin
               st_q <= SAS_IDLE;
            end
         endcase
      end
   end

   sas_sync3 u_cmp_sync
   (
      .clk(pclk),
      .rst_n(presetn),
      .d(cmp_above),
      .q(cmp_s)
   );

   sas_sar #(.N(`SAS_NBITS)) u_sar
   (
      .clk(pclk),
      .rst_n(presetn),
      .load(samp_end & ~wr_mode),
      .decide(decide),
      .idx(idx_q),
      .cmp(cmp_s),
      .sar_q(sar_q),
      .sar_d(sar_d)
   );

   ////////////////////////////////////////////////////////////////////////
   // Result and done pulse; a colliding mode write suppresses both
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         res_q <= `SAS_RES_RST;
         conv_done_irq <= 1'b0;
      end
      else
      begin
         conv_done_irq <= finish & ~wr_mode;
         if (finish && !wr_mode)
            res_q <= sar_d;
      end
   end

   // Analog side; tap lags the trial value by one cycle, covered by step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         analog <= '0;
      else
      begin
         analog.ch_code <= chan_q;
         analog.ref_sel <= (chan_q == `SAS_CODE_REF);
         analog.ch_valid <= (chan_q <= `SAS_CODE_MAX)
                            || (chan_q == `SAS_CODE_REF);
         analog.discharge <= dis_q;
         analog.hold <= (st_q == SAS_TRIAL);
         analog.tap <= sar_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [3:0] ndec_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ndec_q <= 4'h0;
      else if (samp_end)
         ndec_q <= 4'h0;
      else if (decide)
         ndec_q <= ndec_q + 4'h1;
   end

   AST_DONE_STORE: assert property (
      finish && !wr_mode |=> conv_done_irq && res_q == $past(sar_d))
      else $error("Result not stored with done pulse");
   AST_AUTO_CLEAR: assert property (
      finish && !wr_mode |=> !conversion_run_bit && st_q == SAS_IDLE)
      else $error("Run bit not cleared at completion");
   AST_COLLIDE: assert property (
      finish && wr_mode |=> !conv_done_irq && $stable(res_q))
      else $error("Colliding mode write lost to result store");
   AST_ABORT: assert property (
      wr_mode && !pwdata[`SAS_RUN_BIT] |=> st_q == SAS_IDLE
      ##1 !conv_done_irq)
      else $error("Conversion not abandoned");
   AST_NO_START: assert property (
      wr_mode && !en_q |=> !conversion_run_bit && st_q == SAS_IDLE)
      else $error("Run set while converter disabled");
   AST_START: assert property (
      start |=> st_q == SAS_SAMPLE && conversion_run_bit && cnt_q == 8'h00)
      else $error("Run write did not start sampling");
   AST_SAMPLE_LEN: assert property (
      $rose(st_q == SAS_TRIAL) |-> $past(st_q) == SAS_SAMPLE
      && $past(cnt_q) == 8'(SAMPLE_CYC - 1) ##1 analog.hold)
      else $error("Sampling period wrong or hold missing");
   AST_MSB: assert property (
      samp_end && !wr_mode |=> sar_q == `SAS_MSB_TRIAL
      ##1 analog.tap == `SAS_MSB_TRIAL)
      else $error("First trial not at half supply");
   AST_DECIDE: assert property (
      decide && idx_q != 4'h0 |=> sar_q[$past(idx_q)] == $past(cmp_s)
      && sar_q[$past(idx_q) - 4'h1])
      else $error("Trial bit decision wrong");
   AST_TEN: assert property (
      finish |-> ndec_q == 4'h9)
      else $error("Conversion not ten comparisons");
   AST_RES_READ: assert property (
      setup && hit_res && !pwrite |=> prdata[5:0] == 6'h00
      && prdata[15:6] == $past(res_q))
      else $error("Result word layout wrong");
   AST_REF: assert property (
      analog.ref_sel |-> analog.ch_code == `SAS_CODE_REF && analog.ch_valid)
      else $error("Reference select inconsistent");
   AST_IRQ_PULSE: assert property (
      conv_done_irq |=> !conv_done_irq)
      else $error("Done pulse longer than one cycle");
   AST_TAP: assert property (
      analog.hold |-> analog.tap == $past(sar_q))
      else $error("Tap does not follow trial value");
   AST_HOLD_END: assert property (
      $fell(st_q == SAS_TRIAL) |=> !analog.hold)
      else $error("Hold not released after conversion");

   COV_DONE: cover property (@(posedge pclk) disable iff (!presetn)
      finish && !wr_mode);
   COV_ABORT: cover property (@(posedge pclk) disable iff (!presetn)
      wr_mode && !start && st_q == SAS_TRIAL);
   COV_COLLIDE: cover property (@(posedge pclk) disable iff (!presetn)
      finish && wr_mode);
endmodule

// ===== rtl/sas_consts.svh
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH
// Register indices; byte address is four times the index
`define SAS_IDX_TEST 20'hf0013
`define SAS_IDX_CHAN 20'hfff31
`define SAS_IDX_MODE0 20'hfff30
`define SAS_IDX_RES 20'hfff1e
`define SAS_IDX_RESH 20'hfff1f
`define SAS_AW 22
// Reset values
`define SAS_CHAN_RST 4'h0
`define SAS_TEST_RST 1'b0
`define SAS_RES_RST 10'h000
// Field positions and codes
`define SAS_RUN_BIT 7
`define SAS_EN_BIT 0
`define SAS_DIS_BIT 1
`define SAS_CODE_REF 4'hd
`define SAS_CODE_MAX 4'ha
`define SAS_NBITS 10
`define SAS_MSB_TRIAL 10'h200
// Timing
`define SAS_CLK_NS 40
`define SAS_SAMPLE_NS 360
`define SAS_STEP_NS 240
`define SAS_SAMPLE_CYC ((`SAS_SAMPLE_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS)
`define SAS_STEP_CYC ((`SAS_STEP_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS)
`endif

// ===== rtl/sas_pkg.sv
package sas_pkg;
   typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_TRIAL} sas_state_e;
   typedef struct packed
   {
      logic [3:0] ch_code;
      logic ref_sel;
      logic ch_valid;
      logic discharge;
      logic hold;
      logic [9:0] tap;
   } sas_analog_s;
endpackage

// ===== rtl/sas_sync3.sv
`timescale 1ns/1ps
module sas_sync3
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Change is taken only once the last two stages agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            q <= s3_q;
      end
   end
endmodule

// ===== rtl/sas_sar.sv
`timescale 1ns/1ps
module sas_sar #(parameter int N = 10)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic decide,
   input wire logic [3:0] idx,
   input wire logic cmp,
   output logic [N-1:0] sar_q,
   output logic [N-1:0] sar_d
);
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_bit
         always_comb
         begin
            sar_d[i] = sar_q[i];
            if (load)
               sar_d[i] = (i == N - 1);
            else if (decide && idx == 4'(i))
               sar_d[i] = cmp;
            else if (decide && idx == 4'(i + 1))
               sar_d[i] = 1'b1;
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sar_q <= '0;
      else
         sar_q <= sar_d;
   end
endmodule

// ===== testbench/sas_afe_model.sv
`timescale 1ns/1ps
module sas_afe_model
   import sas_pkg::*;
#(
   parameter logic [9:0] REF_CODE = 10'h0d3
)
(
   input wire logic pclk,
   input sas_analog_s analog,
   output logic cmp_above
);
   logic [9:0] vin;
   logic [9:0] held_q;
   logic junk_q;
   ////////////////////////////////////////////////////////////////////////
   // Pin level is a fixed ramp per channel; ground when discharging
   always_comb
   begin
      if (analog.discharge)
         vin = 10'h000;
      else if (analog.ref_sel)
         vin = REF_CODE;
      else
         vin = 10'(analog.ch_code) * 10'd90 + 10'd37;
   end
   ////////////////////////////////////////////////////////////////////////
   // Track while sampling, freeze on hold
   always @(posedge pclk)
   begin
      if (!analog.hold)
         held_q <= vin;
      junk_q <= ~junk_q;
   end
   // Outside hold the comparator output is junk, so it toggles
   assign cmp_above = analog.hold ? (held_q >= analog.tap)
                      : junk_q;
   initial junk_q = 1'b0;
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
`include "sas_consts.svh"
module tb
   import sas_pkg::*;
;
   localparam logic [9:0] REF_CODE = 10'h0d3;
   // Edges from the start commit until the done pulse is seen
   localparam int DONE_EDGES = `SAS_SAMPLE_CYC
                               + `SAS_NBITS * `SAS_STEP_CYC + 1;
   // A write issued this many edges after start commits on the last step
   localparam int COLLIDE_WAIT = DONE_EDGES - 4;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [21:0] paddr = 22'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cmp_above;
   sas_analog_s analog;
   logic conv_done_irq;
   logic run;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [31:0] rdat;
   logic rerr;
   logic [9:0] last_code = 10'h000;

   sas_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_above(cmp_above), .analog(analog),
      .conv_done_irq(conv_done_irq), .conversion_run_bit(run));
   sas_afe_model #(.REF_CODE(REF_CODE)) afe_u (.pclk(pclk),
      .analog(analog), .cmp_above(cmp_above));

   initial
   begin
      forever #20 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task end_of_test;
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         end_of_test;
      end
   end

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s exp %h got %h", name, exp, got);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // One APB transfer; waits for pready with no assumed latency
   task apb(input logic w, input logic [19:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Counts edges until the done pulse, giving up at 200
   task wait_irq(output int n);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (conv_done_irq !== 1'b1 && n < 200);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      apb(0, `SAS_IDX_CHAN, 0);
      chk("chan rst", 32'h0, rdat);
      apb(0, `SAS_IDX_TEST, 0);
      chk("test rst", 32'h0, rdat);
      apb(0, `SAS_IDX_RES, 0);
      chk("res rst", 32'h0, rdat);
      apb(0, `SAS_IDX_RESH, 0);
      chk("resh rst", 32'h0, rdat);
      apb(0, 20'h00123, 0);
      chk("unmapped err", 32'h1, 32'(rerr));
   endtask

   task t_regs;
      apb(1, `SAS_IDX_TEST, 32'h02);
      apb(0, `SAS_IDX_TEST, 0);
      chk("test rw", 32'h02, rdat);
      chk("discharge", 32'h1, 32'(analog.discharge));
      apb(1, `SAS_IDX_TEST, 32'h00);
      apb(1, `SAS_IDX_CHAN, 32'h0d);
      // Analog view is a flop behind the register
      repeat (2) @(posedge pclk);
      chk("ref sel", 32'h1, 32'(analog.ref_sel));
      apb(1, `SAS_IDX_CHAN, 32'h0c);
      repeat (2) @(posedge pclk);
      chk("bad code", 32'h0, 32'(analog.ch_valid));
      apb(1, `SAS_IDX_CHAN, 32'h0a);
      apb(0, `SAS_IDX_CHAN, 0);
      chk("chan rw", 32'h0a, rdat);
      chk("code ten", 32'h1, 32'(analog.ch_valid));
   endtask

   task t_convert(input logic [3:0] ch, input logic dis);
      int n;
      logic [9:0] code;
      code = dis ? 10'h000 : (ch == `SAS_CODE_REF) ? REF_CODE
         : 10'(ch) * 10'd90 + 10'd37;
      apb(1, `SAS_IDX_TEST, {30'h0, dis, 1'b0});
      apb(1, `SAS_IDX_CHAN, {28'h0, ch});
      apb(1, `SAS_IDX_MODE0, 32'h01);
      apb(1, `SAS_IDX_MODE0, 32'h81);
      wait_irq(n);
      chk("done time", 32'(DONE_EDGES), 32'(n));
      chk("run clear", 32'h0, 32'(run));
      @(posedge pclk);
      chk("irq pulse", 32'h0, 32'(conv_done_irq));
      apb(0, `SAS_IDX_RES, 0);
      chk("result", {16'h0, code, 6'h0}, rdat);
      apb(0, `SAS_IDX_RESH, 0);
      chk("result hi", {24'h0, code[9:2]}, rdat);
      last_code = code;
   endtask

   task t_disabled;
      int n;
      apb(1, `SAS_IDX_MODE0, 32'h00);
      apb(1, `SAS_IDX_MODE0, 32'h80);
      @(posedge pclk);
      chk("run ignored", 32'h0, 32'(run));
      wait_irq(n);
      chk("no irq dis", 32'd200, 32'(n));
   endtask

   task t_abort;
      int n;
      apb(1, `SAS_IDX_CHAN, 32'h05);
      apb(1, `SAS_IDX_MODE0, 32'h01);
      apb(1, `SAS_IDX_MODE0, 32'h81);
      repeat (30) @(posedge pclk);
      apb(1, `SAS_IDX_MODE0, 32'h01);
      @(posedge pclk);
      chk("run abort", 32'h0, 32'(run));
      wait_irq(n);
      chk("no irq abort", 32'd200, 32'(n));
      apb(0, `SAS_IDX_RES, 0);
      chk("result kept", {16'h0, last_code, 6'h0}, rdat);
   endtask

   // Mode write committing on the completion edge beats the result store
   task t_collide;
      int n;
      apb(1, `SAS_IDX_CHAN, 32'h03);
      apb(1, `SAS_IDX_MODE0, 32'h01);
      apb(1, `SAS_IDX_MODE0, 32'h81);
      repeat (COLLIDE_WAIT) @(posedge pclk);
      apb(1, `SAS_IDX_MODE0, 32'h01);
      wait_irq(n);
      chk("no irq collide", 32'd200, 32'(n));
      apb(0, `SAS_IDX_RES, 0);
      chk("result collide", {16'h0, last_code, 6'h0}, rdat);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_regs;
      t_convert(4'h3, 1'b0);
      t_convert(4'ha, 1'b0);
      // Discharge run comes before the reference run
      t_convert(4'hd, 1'b1);
      t_convert(4'hd, 1'b0);
      t_convert(4'h0, 1'b0);
      t_abort;
      t_collide;
      t_disabled;
      end_of_test;
   end
endmodule
